// ---- hdl/fsl_pkg.sv ----
// constants, register map and types of the frequent start limiter
//
// Overview of operation
// [R1] each start adds the applicable safe stall time to the starts counter
// [R2] start stress uses only settings, never the measured start duration
// [R3] counter bleeds down each program cycle by starts times stall over the period
// [R4] counter is recomputed every program cycle, not only at starts
// [R5] alarm is raised while exactly one start remains; with one allowed start per period it is never raised
// [R6] inhibit is raised when no start remains, held until one is back
// [R7] inhibit is also raised while the minimum spacing since last start runs
// [R8] motor is hot when used thermal capacity exceeds the hot limit, default 70%
// [R9] while hot and inhibited the counter decays at the hot rate
// [R10] below the hot limit the counter decays at the cold rate
// [R11] hot and cold separation needs valid status from the thermal overload function
// [R12] starts come from the internal start indication only
// [R13] condition reports normal, start, trip or blocked
// [R14] inhibit time, alarm time, starts used and starts available are readable
// [R15] cold safe stall time in 0.1 s, default 20.0 s, zero means use hot
// [R16] motor data is stored once and exported to all other functions
// [R17] allowed starts per period kept for cold and hot, defaults 3 and 2
// [R18] period length in whole hours, default one hour
// [R19] minimum spacing between starts in 0.1 s, default 20.0 s
// [R20] hot safe stall time default 15.0 s, used while hot
// [R21] a block condition reports blocked instead of alarm or inhibit
package fsl_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ           = 25_000_000;
	localparam int CYCLE_MS         = 100;
	localparam int CYCLE_CLOCKS     = CLK_HZ / 1000 * CYCLE_MS;
	localparam int CYCLES_PER_S     = 1000 / CYCLE_MS;
	localparam int SECONDS_PER_HOUR = 3600;
	localparam int CYCLES_PER_HOUR  = SECONDS_PER_HOUR * CYCLES_PER_S;
	// ---------------------------------------------------------------
	// field widths
	// ---------------------------------------------------------------
	localparam int THETA_W = 10;
	localparam int TIME_W  = 13;
	localparam int NUM_W   = 7;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_HOT_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_STALL_HOT = 8'h08;
	localparam logic [7:0] ADDR_STALL_CLD = 8'h0C;
	localparam logic [7:0] ADDR_STARTS    = 8'h10;
	localparam logic [7:0] ADDR_PERIOD    = 8'h14;
	localparam logic [7:0] ADDR_SPACING   = 8'h18;
	localparam logic [7:0] ADDR_STATUS    = 8'h1C;
	localparam logic [7:0] ADDR_COUNTS    = 8'h20;
	localparam logic [7:0] ADDR_INH_TIME  = 8'h24;
	localparam logic [7:0] ADDR_ALM_TIME  = 8'h28;
	localparam logic [7:0] ADDR_COUNTER   = 8'h2C;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int STARTS_HOT_LSB = 8;
	localparam int STAT_ALARM     = 2;
	localparam int STAT_INHIBIT   = 3;
	localparam int STAT_HOT       = 4;
	localparam int STAT_SPACING   = 5;
	localparam int AVAIL_LSB      = 8;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic                RST_ENABLE      = 1'b1;
	localparam logic [THETA_W-1:0]  RST_HOT_LIMIT   = 10'h2BC;
	localparam logic [TIME_W-1:0]   RST_STALL_HOT   = 13'h0096;
	localparam logic [TIME_W-1:0]   RST_STALL_CLD   = 13'h00C8;
	localparam logic [NUM_W-1:0]    RST_STARTS_CLD  = 7'h03;
	localparam logic [NUM_W-1:0]    RST_STARTS_HOT  = 7'h02;
	localparam logic [NUM_W-1:0]    RST_PERIOD_H    = 7'h01;
	localparam logic [TIME_W-1:0]   RST_MIN_SPACING = 13'h00C8;

	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} cond_e;
endpackage

// ---- hdl/cycle_tick.sv ----
// program cycle enable pulse from the system clock
`timescale 1ns/1ps
module cycle_tick #(
	parameter int CLOCKS = 2_500_000
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	localparam int CW = $clog2(CLOCKS);
	logic [CW-1:0] cnt;

	if (CLOCKS < 64) begin : g_clocks_check
		$error("cycle_tick: CLOCKS below 64 starves the drain loop");
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == CW'(CLOCKS - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// ---- hdl/seq_divider.sv ----
// restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module seq_divider #(
	parameter int WIDTH = 40
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             go,
	input  wire logic [WIDTH-1:0] num,
	input  wire logic [WIDTH-1:0] den,
	output logic                  busy,
	output logic                  done,
	output logic [WIDTH-1:0]      quot
);
	localparam int CW = $clog2(WIDTH + 1);
	logic [WIDTH-1:0] rem;
	logic [WIDTH-1:0] dvs;
	logic [CW-1:0]    left;
	logic [WIDTH:0]   trial;

	if (WIDTH < 2) begin : g_width_check
		$error("seq_divider: WIDTH below 2");
	end

	assign trial = {rem, quot[WIDTH-1]} - {1'b0, dvs};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rem  <= '0;
			dvs  <= '0;
			quot <= '0;
			left <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (go && !busy) begin
				rem  <= '0;
				dvs  <= den;
				quot <= num;
				left <= CW'(WIDTH);
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[WIDTH]) begin
					rem  <= trial[WIDTH-1:0];
					quot <= {quot[WIDTH-2:0], 1'b1};
				end else begin
					rem  <= {rem[WIDTH-2:0], quot[WIDTH-1]};
					quot <= {quot[WIDTH-2:0], 1'b0};
				end
				left <= left - 1'b1;
				if (left == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- hdl/frequent_start_limiter.sv ----
// frequent start limiter with AHB-Lite settings and status
`timescale 1ns/1ps
module frequent_start_limiter #(
	parameter int CYCLE_CLOCKS = fsl_pkg::CYCLE_CLOCKS
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic                             hreadyout,
	output logic [31:0]                      hrdata,
	output logic                             hresp,
	input  wire logic                        motor_start_indication,
	input  wire logic [fsl_pkg::THETA_W-1:0] thermal_used_permille,
	input  wire logic                        thermal_status_valid,
	input  wire logic                        block_pin,
	output logic                             start_alarm,
	output logic                             restart_inhibit,
	output fsl_pkg::cond_e                   condition,
	output logic [7:0]                       starts_used,
	output logic [7:0]                       starts_available,
	output logic [19:0]                      inhibit_time_s,
	output logic [19:0]                      alarm_time_s,
	output logic [fsl_pkg::THETA_W-1:0]      hot_limit_setting,
	output logic [fsl_pkg::TIME_W-1:0]       stall_hot_setting,
	output logic [fsl_pkg::TIME_W-1:0]       stall_cold_setting
);
	localparam int DW = 40;
	typedef enum {SEQ_IDLE, SEQ_USED, SEQ_INH, SEQ_ALM} seq_e;

	logic                        enable;
	logic [fsl_pkg::TIME_W-1:0]  stall_cold;
	logic [fsl_pkg::NUM_W-1:0]   starts_cold;
	logic [fsl_pkg::NUM_W-1:0]   starts_hot;
	logic [fsl_pkg::NUM_W-1:0]   period_h;
	logic [fsl_pkg::TIME_W-1:0]  min_spacing;
	logic [7:0]                  wr_addr;
	logic [7:0]                  rd_addr;
	logic                        wr_pend;
	logic                        rd_pend;
	logic [1:0]                  blk_sync;
	logic                        blocked;
	logic                        start_q;
	logic                        start_edge;
	logic                        tick;
	logic                        hot;
	logic [fsl_pkg::TIME_W-1:0]  stall;
	logic [fsl_pkg::NUM_W-1:0]   n_allow;
	logic [19:0]                 cap_full;
	logic [19:0]                 inh_th;
	logic [19:0]                 alm_lo;
	logic [22:0]                 period_cycles;
	logic [18:0]                 period_secs;
	logic [20:0]                 counter;
	logic [20:0]                 next_counter;
	logic [22:0]                 acc;
	logic                        draining;
	logic [fsl_pkg::TIME_W-1:0]  since_start;
	logic                        spacing_block;
	logic                        inhibit_raw;
	logic                        alarm_raw;
	seq_e                        seq;
	logic                        launched;
	logic                        div_go;
	logic                        div_busy;
	logic                        div_done;
	logic [DW-1:0]               div_num;
	logic [DW-1:0]               div_den;
	logic [DW-1:0]               div_q;
	logic [31:0]                 rd_mux;

	function automatic logic [fsl_pkg::NUM_W-1:0] at_least_one(input logic [fsl_pkg::NUM_W-1:0] v);
		return (v == '0) ? fsl_pkg::NUM_W'(1) : v;
	endfunction

	function automatic logic [19:0] sat20(input logic [DW-1:0] v);
		return (v > DW'(20'hFFFFF)) ? 20'hFFFFF : v[19:0];
	endfunction

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	// reads take one wait state so that a write just before is seen
	assign hreadyout = !rd_pend;
	assign hresp     = 1'b0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= '0;
			rd_addr <= '0;
		end else begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				wr_pend <= hwrite;
				rd_pend <= !hwrite;
				wr_addr <= {haddr[7:2], 2'b00};
				rd_addr <= {haddr[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable             <= fsl_pkg::RST_ENABLE;
			hot_limit_setting  <= fsl_pkg::RST_HOT_LIMIT;
			stall_hot_setting  <= fsl_pkg::RST_STALL_HOT;
			stall_cold         <= fsl_pkg::RST_STALL_CLD;
			starts_cold        <= fsl_pkg::RST_STARTS_CLD;
			starts_hot         <= fsl_pkg::RST_STARTS_HOT;
			period_h           <= fsl_pkg::RST_PERIOD_H;
			min_spacing        <= fsl_pkg::RST_MIN_SPACING;
		end else if (wr_pend) begin
			case (wr_addr)
				fsl_pkg::ADDR_CTRL: enable <= hwdata[0];
				fsl_pkg::ADDR_HOT_LIMIT: hot_limit_setting <= hwdata[fsl_pkg::THETA_W-1:0]; // [R8]
				fsl_pkg::ADDR_STALL_HOT: begin
					// zero stall would make every start free
					stall_hot_setting <= (hwdata[12:0] == '0) ? 13'h0001 : hwdata[12:0]; // [R20]
				end
				fsl_pkg::ADDR_STALL_CLD: stall_cold <= hwdata[fsl_pkg::TIME_W-1:0]; // [R15]
				fsl_pkg::ADDR_STARTS: begin
					starts_cold <= at_least_one(hwdata[fsl_pkg::NUM_W-1:0]); // [R17]
					starts_hot  <= at_least_one(hwdata[fsl_pkg::STARTS_HOT_LSB +: fsl_pkg::NUM_W]);
				end
				fsl_pkg::ADDR_PERIOD: period_h <= at_least_one(hwdata[fsl_pkg::NUM_W-1:0]); // [R18]
				fsl_pkg::ADDR_SPACING: min_spacing <= hwdata[fsl_pkg::TIME_W-1:0]; // [R19]
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_mux = '0;
		case (rd_addr)
			fsl_pkg::ADDR_CTRL: rd_mux = {31'h0, enable};
			fsl_pkg::ADDR_HOT_LIMIT: rd_mux = {22'h0, hot_limit_setting};
			fsl_pkg::ADDR_STALL_HOT: rd_mux = {19'h0, stall_hot_setting};
			fsl_pkg::ADDR_STALL_CLD: rd_mux = {19'h0, stall_cold};
			fsl_pkg::ADDR_STARTS: rd_mux = {17'h0, starts_hot, 1'b0, starts_cold};
			fsl_pkg::ADDR_PERIOD: rd_mux = {25'h0, period_h};
			fsl_pkg::ADDR_SPACING: rd_mux = {19'h0, min_spacing};
			fsl_pkg::ADDR_STATUS: begin
				rd_mux[1:0]                   = condition; // [R13]
				rd_mux[fsl_pkg::STAT_ALARM]   = start_alarm;
				rd_mux[fsl_pkg::STAT_INHIBIT] = restart_inhibit;
				rd_mux[fsl_pkg::STAT_HOT]     = hot;
				rd_mux[fsl_pkg::STAT_SPACING] = spacing_block;
			end
			fsl_pkg::ADDR_COUNTS: rd_mux = {16'h0, starts_available, starts_used}; // [R14]
			fsl_pkg::ADDR_INH_TIME: rd_mux = {12'h0, inhibit_time_s};
			fsl_pkg::ADDR_ALM_TIME: rd_mux = {12'h0, alarm_time_s};
			fsl_pkg::ADDR_COUNTER: rd_mux = {11'h0, counter};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= '0;
		end else if (rd_pend) begin
			hrdata <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// inputs and motor data
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blk_sync <= '0;
			start_q  <= 1'b0;
		end else begin
			blk_sync <= {blk_sync[0], block_pin};
			start_q  <= motor_start_indication;
		end
	end

	assign blocked    = blk_sync[1];
	assign start_edge = enable && motor_start_indication && !start_q; // [R12]

	// settings leave as ports so every user sees an edit in the same cycle
	assign stall_cold_setting = (stall_cold == '0) ? stall_hot_setting : stall_cold; // [R15] [R16]
	assign hot     = thermal_status_valid && (thermal_used_permille > hot_limit_setting); // [R8] [R11]
	assign stall   = hot ? stall_hot_setting : stall_cold_setting; // [R20]
	assign n_allow = hot ? starts_hot : starts_cold; // [R17]

	// thresholds in the counter's own unit, start stress from settings only
	assign cap_full      = 20'(n_allow) * 20'(stall); // [R2]
	assign inh_th        = cap_full - 20'(stall);
	assign alm_lo        = (inh_th >= 20'(stall)) ? inh_th - 20'(stall) : '0;
	assign period_cycles = 23'(period_h) * 23'(fsl_pkg::CYCLES_PER_HOUR);
	assign period_secs   = 19'(period_h) * 19'(fsl_pkg::SECONDS_PER_HOUR);

	cycle_tick #(
		.CLOCKS (CYCLE_CLOCKS)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	// ---------------------------------------------------------------
	// starts counter
	// ---------------------------------------------------------------
	// the bleed is n*stall per period: each cycle adds n*stall to acc and
	// acc is drained one unit per clock, one period_cycles at a time
	assign draining = !tick && (acc >= 23'(period_cycles)) && (counter != '0); // [R3]

	always_comb begin
		next_counter = draining ? counter - 1'b1 : counter; // [R9] [R10]
		if (start_edge) begin
			// same stress whatever the start lasts
			if (next_counter > 21'h1FFFFF - 21'(stall)) begin
				next_counter = 21'h1FFFFF;
			end else begin
				next_counter = next_counter + 21'(stall); // [R1]
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter <= '0;
		end else if (!enable) begin
			counter <= '0;
		end else begin
			counter <= next_counter;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= '0;
		end else if (!enable || (counter == '0 && !start_edge)) begin
			acc <= '0;
		end else if (tick) begin
			acc <= acc + 23'(cap_full); // [R3] [R4]
		end else if (draining) begin
			acc <= acc - 23'(period_cycles);
		end
	end

	// ---------------------------------------------------------------
	// spacing between starts
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_start <= '1;
		end else if (start_edge) begin
			since_start <= '0;
		end else if (tick && since_start != '1) begin
			since_start <= since_start + 1'b1;
		end
	end

	assign spacing_block = since_start < min_spacing; // [R7]
	assign inhibit_raw   = (counter > 21'(inh_th)) || spacing_block; // [R6] [R7]
	assign alarm_raw     = (counter > 21'(alm_lo)) && (counter <= 21'(inh_th)); // [R5]

	// ---------------------------------------------------------------
	// outputs and condition
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_alarm     <= 1'b0;
			restart_inhibit <= 1'b0;
			condition       <= fsl_pkg::COND_NORMAL;
		end else begin
			start_alarm     <= enable && !blocked && alarm_raw; // [R5] [R21]
			restart_inhibit <= enable && !blocked && inhibit_raw; // [R6] [R21]
			if (!enable) begin
				condition <= fsl_pkg::COND_NORMAL;
			end else if (blocked) begin
				condition <= fsl_pkg::COND_BLOCKED; // [R21]
			end else if (inhibit_raw) begin
				condition <= fsl_pkg::COND_TRIP; // [R13]
			end else if (alarm_raw) begin
				condition <= fsl_pkg::COND_START;
			end else begin
				condition <= fsl_pkg::COND_NORMAL;
			end
		end
	end

	// ---------------------------------------------------------------
	// figures sequencer
	// ---------------------------------------------------------------
	// one shared divider; figures refresh at the first program cycle tick after the previous three divisions end
	assign div_go = (seq != SEQ_IDLE) && !launched;

	always_comb begin
		div_den = DW'(stall);
		div_num = DW'(counter) + DW'(stall) - 1'b1;
		case (seq)
			SEQ_INH: begin
				div_den = DW'(cap_full);
				div_num = (counter > 21'(inh_th)) ?
					DW'(counter - 21'(inh_th)) * DW'(period_secs) + DW'(cap_full) - 1'b1 : '0;
			end
			SEQ_ALM: begin
				div_den = DW'(cap_full);
				div_num = (counter > 21'(alm_lo)) ?
					DW'(counter - 21'(alm_lo)) * DW'(period_secs) + DW'(cap_full) - 1'b1 : '0;
			end
			default: ;
		endcase
	end

	seq_divider #(
		.WIDTH (DW)
	) u_div (
		.clk  (clk),
		.rst  (rst),
		.go   (div_go),
		.num  (div_num),
		.den  (div_den),
		.busy (div_busy),
		.done (div_done),
		.quot (div_q)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq              <= SEQ_IDLE;
			launched         <= 1'b0;
			starts_used      <= '0;
			starts_available <= '0;
			inhibit_time_s   <= '0;
			alarm_time_s     <= '0;
		end else begin
			if (div_go) launched <= 1'b1;
			case (seq)
				SEQ_IDLE: if (tick) seq <= SEQ_USED;
				SEQ_USED: if (div_done) begin
					starts_used      <= 8'(sat20(div_q)); // [R14]
					starts_available <= (div_q < DW'(n_allow)) ? 8'(DW'(n_allow) - div_q) : '0;
					launched         <= 1'b0;
					seq              <= SEQ_INH;
				end
				SEQ_INH: if (div_done) begin
					inhibit_time_s <= sat20(div_q); // [R14]
					launched       <= 1'b0;
					seq            <= SEQ_ALM;
				end
				SEQ_ALM: if (div_done) begin
					alarm_time_s <= sat20(div_q);
					launched     <= 1'b0;
					seq          <= SEQ_IDLE;
				end
				default: seq <= SEQ_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_start_stress: assert property (start_edge && !draining && counter < 21'h10_0000 // [R1]
		|=> counter == $past(counter) + 21'($past(stall)))
		else $error("start did not add the safe stall time");
	a_stress_fixed: assert property (start_edge ##1 (motor_start_indication // [R2]
		&& enable && !draining) |=> $stable(counter))
		else $error("held start indication changed the counter");
	a_cycle_bleed: assert property (tick && enable && counter != '0 && !start_edge // [R3]
		|=> acc == $past(acc) + 23'($past(cap_full)))
		else $error("program cycle did not load the bleed");
	a_drain_step: assert property (draining && !start_edge && enable // [R4]
		|=> counter == $past(counter) - 1'b1)
		else $error("counter did not bleed one unit");
	a_alarm_band: assert property (start_alarm |-> !$past(blocked) // [R5]
		&& $past(counter) <= 21'($past(inh_th))
		&& $past(counter) + 21'($past(stall)) > 21'($past(inh_th)))
		else $error("alarm outside one remaining start");
	a_inhibit_hold: assert property (enable && !blocked && counter > 21'(inh_th) // [R6]
		&& $stable(counter) |=> restart_inhibit)
		else $error("inhibit missing with no start left");
	a_spacing_block: assert property (start_edge && min_spacing != '0 && !blocked // [R7]
		|-> ##2 restart_inhibit)
		else $error("spacing did not inhibit");
	a_hot_class: assert property (thermal_status_valid && start_edge && !draining // [R8]
		&& thermal_used_permille > hot_limit_setting && counter < 21'h10_0000
		|=> counter == $past(counter) + 21'($past(stall_hot_setting)))
		else $error("hot start did not add the hot stall time");
	a_blocked_cond: assert property (enable && blocked // [R21]
		|=> condition == fsl_pkg::COND_BLOCKED && !start_alarm && !restart_inhibit)
		else $error("blocked did not override");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_inhibit: cover property ($rose(restart_inhibit));
	c_alarm: cover property ($rose(start_alarm));
	c_hot_start: cover property (start_edge && hot);
	c_blocked: cover property (condition == fsl_pkg::COND_BLOCKED);
endmodule

// ---- tb/motor_partner.sv ----
// model of the motor status and thermal overload functions
`timescale 1ns/1ps
module motor_partner (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start_req,
	input  wire logic [9:0] theta,
	input  wire logic       tol_on,
	output logic            motor_start_indication,
	output logic [9:0]      thermal_used_permille,
	output logic            thermal_status_valid
);
	logic [2:0] run;
	// start held a few clocks so the limiter sees one clean rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run <= 3'h0;
		end else if (start_req) begin
			run <= 3'h4;
		end else if (run != 3'h0) begin
			run <= run - 3'h1;
		end
	end
	assign motor_start_indication = (run != 3'h0);
	// status is only offered while the overload function is switched on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thermal_used_permille <= 10'h000;
			thermal_status_valid  <= 1'b0;
		end else begin
			thermal_used_permille <= theta;
			thermal_status_valid  <= tol_on;
		end
	end
endmodule

// ---- tb/frequent_start_limiter_tb_top.sv ----
// self-checking bench of the frequent start limiter
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module frequent_start_limiter_tb_top;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic        start_req = 1'b0, tol_on = 1'b0, block_pin = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, q;
	logic [1:0]  htrans = 2'h0;
	logic [9:0]  theta = 10'h000;
	int          compares = 0, errors = 0;
	wire logic   hreadyout, msi, tvalid, start_alarm, restart_inhibit;
	wire logic [31:0] hrdata;
	wire logic [9:0]  tused, hot_limit_setting;
	wire logic [7:0]  starts_available;
	wire logic [12:0] stall_hot_setting, stall_cold_setting;
	fsl_pkg::cond_e   condition;
	// short program cycle keeps the run brief; all waits below assume it
	frequent_start_limiter #(.CYCLE_CLOCKS(100)) i_dut (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
		.motor_start_indication(msi), .thermal_used_permille(tused),
		.thermal_status_valid(tvalid), .block_pin(block_pin), .start_alarm(start_alarm),
		.restart_inhibit(restart_inhibit), .condition(condition), .starts_used(),
		.starts_available(starts_available), .inhibit_time_s(), .alarm_time_s(),
		.hot_limit_setting(hot_limit_setting), .stall_hot_setting(stall_hot_setting),
		.stall_cold_setting(stall_cold_setting));
	motor_partner i_partner (.clk(clk), .rst(rst), .start_req(start_req), .theta(theta),
		.tol_on(tol_on), .motor_start_indication(msi), .thermal_used_permille(tused),
		.thermal_status_valid(tvalid));
	always #20 clk = ~clk;
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// ready and read data are taken at the rising edge, as the slave sees them
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic kick();
		@(posedge clk);
		start_req <= 1'b1;
		@(posedge clk);
		start_req <= 1'b0;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] e [8];
		e = '{32'h1, 32'h2BC, 32'h96, 32'hC8, 32'h203, 32'h1, 32'hC8, 32'h0};
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, (i == 7) ? 8'h30 : 8'(i * 4), 32'h0);
			`CHK(q, e[i])
		end
		$display("reset values test done");
	endtask
	task automatic t_spacing();
		bus(1'b1, 8'h18, 32'h2);
		kick();
		cyc(8);
		`CHK(restart_inhibit, 1'b1)
		`CHK(condition, fsl_pkg::COND_TRIP)
		cyc(400);
		`CHK(restart_inhibit, 1'b0)
		bus(1'b0, 8'h2C, 32'h0);
		`CHK(q > 32'hBE && q <= 32'hC8, 1'b1)
		$display("spacing test done");
	endtask
	task automatic t_count();
		logic [31:0] c1;
		kick();
		cyc(400);
		`CHK(start_alarm, 1'b1)
		`CHK(condition, fsl_pkg::COND_START)
		kick();
		cyc(400);
		`CHK({start_alarm, restart_inhibit}, 2'h1)
		`CHK(starts_available, 8'h00)
		bus(1'b0, 8'h20, 32'h0);
		`CHK(q, 32'h0003)
		bus(1'b0, 8'h24, 32'h0);
		`CHK(q, 32'h04B0)
		bus(1'b0, 8'h28, 32'h0);
		`CHK(q, 32'h0960)
		bus(1'b0, 8'h2C, 32'h0);
		c1 = q;
		cyc(7000);
		bus(1'b0, 8'h2C, 32'h0);
		`CHK(q < c1 && q + 32'h3 > c1, 1'b1)
		$display("start count test done");
	endtask
	task automatic t_block();
		@(posedge clk);
		block_pin <= 1'b1;
		cyc(6);
		`CHK(condition, fsl_pkg::COND_BLOCKED)
		`CHK({start_alarm, restart_inhibit}, 2'h0)
		@(posedge clk);
		block_pin <= 1'b0;
		cyc(6);
		`CHK(restart_inhibit, 1'b1)
		$display("block test done");
	endtask
	task automatic t_hot();
		logic [2:0] h;
		logic [31:0] c;
		@(posedge clk);
		theta <= 10'h2BD;
		cyc(250);
		bus(1'b0, 8'h1C, 32'h0);
		h[0] = q[4];
		@(posedge clk);
		tol_on <= 1'b1;
		cyc(250);
		bus(1'b0, 8'h1C, 32'h0);
		h[1] = q[4];
		bus(1'b0, 8'h2C, 32'h0);
		c = q;
		kick();
		bus(1'b0, 8'h2C, 32'h0);
		`CHK(q - c, 32'h96)
		@(posedge clk);
		theta <= 10'h2BC;
		cyc(250);
		bus(1'b0, 8'h1C, 32'h0);
		h[2] = q[4];
		`CHK(h, 3'h2)
		bus(1'b1, 8'h0C, 32'h0);
		bus(1'b1, 8'h04, 32'h64);
		cyc(1);
		`CHK(stall_cold_setting, 13'h0096)
		`CHK(stall_hot_setting, 13'h0096)
		`CHK(hot_limit_setting, 10'h064)
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b0, 8'h2C, 32'h0);
		`CHK({q, condition, restart_inhibit}, 35'h0)
		$display("hot cold test done");
	endtask
	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_spacing();
		t_count();
		t_block();
		t_hot();
		summarize();
	end
	// the tests need about 10k clocks; four times that means a hang
	initial begin
		#1_600_000;
		errors++;
		summarize();
	end
endmodule
